/* File: src/at8_defs.svh */
// Offsets, field positions, reset values and timing counts of the timer
`ifndef AT8_DEFS_SVH
`define AT8_DEFS_SVH

// ==========================================================
// Register byte offsets on the bus
`define AT8_OFS_CTRL_A 8'h00
`define AT8_OFS_CTRL_B 8'h04
`define AT8_OFS_COUNT 8'h08
`define AT8_OFS_CMP_A 8'h0c
`define AT8_OFS_CMP_B 8'h10
`define AT8_OFS_STATUS 8'h14

// ==========================================================
// Control register B fields
`define AT8_B_FORCE_A 7
`define AT8_B_FORCE_B 6
`define AT8_B_WAVE_MSB 3
`define AT8_B_CS_HI 2
`define AT8_B_CS_LO 0
`define AT8_B_RW_MASK 8'h0f

// ==========================================================
// Control register A fields
`define AT8_A_ACT_A_HI 7
`define AT8_A_ACT_A_LO 6
`define AT8_A_ACT_B_HI 5
`define AT8_A_ACT_B_LO 4
`define AT8_A_WAVE_HI 1
`define AT8_A_WAVE_LO 0
`define AT8_A_RW_MASK 8'hf3

// ==========================================================
// Async status fields
`define AT8_S_EXT_CLK 6
`define AT8_S_ASYNC 5
`define AT8_S_CNT_BUSY 4
`define AT8_S_CMPA_BUSY 3
`define AT8_S_CMPB_BUSY 2
`define AT8_S_CTLA_BUSY 1
`define AT8_S_CTLB_BUSY 0

// ==========================================================
// Reset values and counts
`define AT8_RST_BYTE 8'h00
`define AT8_MAX 8'hff
`define AT8_BOTTOM 8'h00
`define AT8_OSC_EDGES 2'h2
`define AT8_NUM_SYNC 5

`endif

/* File: src/at8_pkg.sv */
// Types shared by the timer files
package at8_pkg;
   // Index of each register that is written through temporary storage
   typedef enum logic [2:0] {
      AT8_SLOT_COUNT = 3'h0,
      AT8_SLOT_CMP_A = 3'h1,
      AT8_SLOT_CMP_B = 3'h2,
      AT8_SLOT_CTL_A = 3'h3,
      AT8_SLOT_CTL_B = 3'h4
   } at8_slot_t;

   // Compare output action codes
   typedef enum logic [1:0] {
      AT8_ACT_OFF = 2'h0,
      AT8_ACT_TOGGLE = 2'h1,
      AT8_ACT_CLEAR = 2'h2,
      AT8_ACT_SET = 2'h3
   } at8_action_t;

   typedef logic [7:0] at8_byte_t;
endpackage

/* File: src/at8_upd_slot.sv */
// One temporary register with its update-busy flag and delayed load
`timescale 1ns/1ps
`default_nettype none
`include "at8_defs.svh"

module at8_upd_slot (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic async_i,
   input wire logic wr_i,
   input wire at8_pkg::at8_byte_t wdata_i,
   input wire logic osc_rise_i,
   output at8_pkg::at8_byte_t tmp_o,
   output logic busy_o,
   output logic load_o
);
   import at8_pkg::*;

   logic [1:0] edges;
   logic [1:0] next_edges;
   wire async_done;
   wire sync_load;

   // ==========================================================
   // Edge counting and load
   assign next_edges = osc_rise_i ? edges + 2'h1 : edges;
   assign async_done = busy_o && osc_rise_i &&
                       (next_edges == `AT8_OSC_EDGES); // R19
   assign sync_load = wr_i && !async_i;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tmp_o <= `AT8_RST_BYTE;
         busy_o <= 1'b0;
         edges <= 2'h0;
         load_o <= 1'b0;
      end else begin
         load_o <= sync_load || async_done;
         if (wr_i) begin
            tmp_o <= wdata_i;
         end
         // A fresh write restarts the wait and wins over the clear
         if (wr_i && async_i) begin
            busy_o <= 1'b1; // R14 R15
            edges <= 2'h0;
         end else if (async_done) begin
            busy_o <= 1'b0; // R14 R15 R20
            edges <= 2'h0;
         end else if (busy_o) begin
            edges <= next_edges;
         end
      end
   end
endmodule
`default_nettype wire

/* File: src/at8_timer.sv */
// 8-bit timer with prescaler, two compare channels and async write path
//
// Overview of operation
// R01: Writing one to force bit 7 or 6 forces a compare in non-PWM modes.
// R02: A forced compare raises no interrupt and never clears the counter.
// R03: Force bits are write-only strobes and read back as zero.
// R04: Software writes zero to force bits while in a PWM mode.
// R05: Control B bits 5:4 are reserved, read zero, ignore writes.
// R06: Clock select: stop, /1, /8, /32, /64, /128, /256, /1024.
// R07: Counter register is directly readable and writable, eight bits.
// R08: After a counter write, the match on the next timer clock is blocked.
// R09: Both compare registers are checked against the counter every tick.
// R10: External clock buffer on with async; crystal runs only if bit is zero.
// R11: Software sets the external clock bit before selecting async clocking.
// R12: Async select zero uses the system clock, one uses the oscillator pin.
// R13: Timer registers need not survive a change of async select.
// R14: Async counter write sets its busy flag until the value is loaded.
// R15: Async writes to compares and controls set busy bits 3 to 0.
// R16: Software never writes a register whose busy flag is set.
// R17: Counter reads the live count; others read their temporary storage.
// R18: Waveform msb in control B joins two low bits from control A.
// R19: Async writes land after two rising edges of the oscillator.
// R20: Busy flags clear through a synchronizer into the system clock.
//
// The Wishbone slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "at8_defs.svh"

module at8_timer (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic timer_osc_pin_i,
   output logic compare_out_a_o,
   output logic compare_out_b_o,
   output logic compare_match_a_o,
   output logic compare_match_b_o,
   output logic ext_clock_input_en_o,
   output logic xtal_osc_en_o
);
   import at8_pkg::*;

   // ==========================================================
   // Bus decode
   wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire wr_req = req && wb_we_i && wb_sel_i[0];
   wire hit_ctl_a = (wb_adr_i == `AT8_OFS_CTRL_A);
   wire hit_ctl_b = (wb_adr_i == `AT8_OFS_CTRL_B);
   wire hit_count = (wb_adr_i == `AT8_OFS_COUNT);
   wire hit_cmp_a = (wb_adr_i == `AT8_OFS_CMP_A);
   wire hit_cmp_b = (wb_adr_i == `AT8_OFS_CMP_B);
   wire hit_status = (wb_adr_i == `AT8_OFS_STATUS);
   wire [7:0] wbyte = wb_dat_i[7:0];

   // ==========================================================
   // Async status register
   logic ext_clk_en;
   logic async_sel;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ext_clk_en <= 1'b0;
         async_sel <= 1'b0;
      end else if (wr_req && hit_status) begin
         ext_clk_en <= wbyte[`AT8_S_EXT_CLK];
         // Contents written before a switch are not kept valid
         async_sel <= wbyte[`AT8_S_ASYNC]; // R12 R13
      end
   end

   // ==========================================================
   // Oscillator pin: two flops, then edge detect on the settled copy
   logic osc_meta;
   logic osc_sync;
   logic osc_last;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         osc_meta <= 1'b0;
         osc_sync <= 1'b0;
         osc_last <= 1'b0;
      end else begin
         osc_meta <= timer_osc_pin_i;
         osc_sync <= osc_meta;
         osc_last <= osc_sync;
      end
   end

   wire osc_rise = osc_sync && !osc_last;
   // Pin edges only count while the oscillator path is the source
   wire osc_edge = osc_rise && async_sel;
   wire src_tick = async_sel ? osc_rise : 1'b1; // R12

   // ==========================================================
   // Write slots, one per synchronized register
   wire [`AT8_NUM_SYNC-1:0] slot_wr;
   wire [`AT8_NUM_SYNC-1:0] slot_busy;
   wire [`AT8_NUM_SYNC-1:0] slot_load;
   at8_byte_t slot_tmp [`AT8_NUM_SYNC];

   assign slot_wr[AT8_SLOT_COUNT] = wr_req && hit_count;
   assign slot_wr[AT8_SLOT_CMP_A] = wr_req && hit_cmp_a;
   assign slot_wr[AT8_SLOT_CMP_B] = wr_req && hit_cmp_b;
   assign slot_wr[AT8_SLOT_CTL_A] = wr_req && hit_ctl_a;
   assign slot_wr[AT8_SLOT_CTL_B] = wr_req && hit_ctl_b;

   genvar gi;
   generate
      for (gi = 0; gi < `AT8_NUM_SYNC; gi = gi + 1) begin : g_slot
         at8_upd_slot u_slot (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .async_i(async_sel),
            .wr_i(slot_wr[gi]),
            .wdata_i(wbyte),
            .osc_rise_i(osc_edge),
            .tmp_o(slot_tmp[gi]),
            .busy_o(slot_busy[gi]),
            .load_o(slot_load[gi])
         );
      end
   endgenerate

   // ==========================================================
   // Destination registers
   logic [7:0] count;
   logic [7:0] cmp_a;
   logic [7:0] cmp_b;
   logic [7:0] ctl_a;
   logic [7:0] ctl_b;

   wire count_load = slot_load[AT8_SLOT_COUNT];
   wire ctl_b_load = slot_load[AT8_SLOT_CTL_B];
   wire [7:0] ctl_b_src = slot_tmp[AT8_SLOT_CTL_B];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cmp_a <= `AT8_RST_BYTE;
         cmp_b <= `AT8_RST_BYTE;
         ctl_a <= `AT8_RST_BYTE;
         ctl_b <= `AT8_RST_BYTE;
      end else begin
         if (slot_load[AT8_SLOT_CMP_A]) begin
            cmp_a <= slot_tmp[AT8_SLOT_CMP_A];
         end
         if (slot_load[AT8_SLOT_CMP_B]) begin
            cmp_b <= slot_tmp[AT8_SLOT_CMP_B];
         end
         if (slot_load[AT8_SLOT_CTL_A]) begin
            ctl_a <= slot_tmp[AT8_SLOT_CTL_A] & `AT8_A_RW_MASK;
         end
         if (ctl_b_load) begin
            // Force bits and reserved bits are never stored
            ctl_b <= ctl_b_src & `AT8_B_RW_MASK; // R03 R05
         end
      end
   end

   // ==========================================================
   // Mode decode
   wire [2:0] wave = {ctl_b[`AT8_B_WAVE_MSB],
                      ctl_a[`AT8_A_WAVE_HI:`AT8_A_WAVE_LO]}; // R18
   wire is_pwm = wave[0];
   wire is_fast = (wave[1:0] == 2'h3);
   wire is_phase = wave[0] && !wave[1];
   wire is_ctc = (wave == 3'h2);
   wire top_from_a = wave[2] || is_ctc; // R18
   wire [7:0] top = top_from_a ? cmp_a : `AT8_MAX;
   wire [2:0] clk_sel = ctl_b[`AT8_B_CS_HI:`AT8_B_CS_LO];
   wire [1:0] act_a = ctl_a[`AT8_A_ACT_A_HI:`AT8_A_ACT_A_LO];
   wire [1:0] act_b = ctl_a[`AT8_A_ACT_B_HI:`AT8_A_ACT_B_LO];

   // ==========================================================
   // Prescaler
   logic [9:0] pre_cnt;
   logic pre_hit;

   always_comb begin
      unique case (clk_sel) // R06
         3'h0: pre_hit = 1'b0;
         3'h1: pre_hit = 1'b1;
         3'h2: pre_hit = (pre_cnt[2:0] == 3'h7);
         3'h3: pre_hit = (pre_cnt[4:0] == 5'h1f);
         3'h4: pre_hit = (pre_cnt[5:0] == 6'h3f);
         3'h5: pre_hit = (pre_cnt[6:0] == 7'h7f);
         3'h6: pre_hit = (pre_cnt[7:0] == 8'hff);
         3'h7: pre_hit = (pre_cnt == 10'h3ff);
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pre_cnt <= 10'h000;
      end else if (src_tick) begin
         pre_cnt <= pre_cnt + 10'h001;
      end
   end

   wire tick = src_tick && pre_hit;

   // ==========================================================
   // Counter, compare and direction
   logic count_up;
   logic block_match;
   logic [7:0] next_count;
   logic next_up;

   // Match removed on the tick after a counter write
   wire eq_a = (count == cmp_a) && !block_match; // R08 R09
   wire eq_b = (count == cmp_b) && !block_match; // R08 R09
   wire at_top = (count == top);

   always_comb begin
      next_up = count_up;
      if (is_phase) begin
         if (count_up && at_top) begin
            next_up = 1'b0;
            next_count = count - 8'h01;
         end else if (!count_up && count == `AT8_BOTTOM) begin
            next_up = 1'b1;
            next_count = count + 8'h01;
         end else begin
            next_count = count_up ? count + 8'h01 : count - 8'h01;
         end
      end else if ((is_ctc || is_fast) && at_top) begin
         next_count = `AT8_BOTTOM;
      end else begin
         next_count = count + 8'h01;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         count <= `AT8_RST_BYTE;
         count_up <= 1'b1;
         block_match <= 1'b0;
      end else if (count_load) begin
         count <= slot_tmp[AT8_SLOT_COUNT]; // R07
         block_match <= 1'b1; // R08
      end else if (tick) begin
         count <= next_count;
         count_up <= next_up;
         block_match <= 1'b0;
      end
   end

   // ==========================================================
   // Waveform outputs
   function automatic logic out_next(input logic [1:0] act,
                                     input logic cur,
                                     input logic eq,
                                     input logic wrap,
                                     input logic up,
                                     input logic chan_a);
      logic res;
      res = cur;
      if (!is_pwm) begin
         if (eq) begin
            unique case (act)
               AT8_ACT_OFF: res = cur;
               AT8_ACT_TOGGLE: res = !cur;
               AT8_ACT_CLEAR: res = 1'b0;
               AT8_ACT_SET: res = 1'b1;
            endcase
         end
      end else if (act[1]) begin
         if (is_fast && wrap) begin
            res = !act[0];
         end else if (is_fast && eq) begin
            res = act[0];
         end else if (is_phase && eq) begin
            res = up ? act[0] : !act[0];
         end
      end else if (act[0] && chan_a && wave[2] && eq) begin
         res = !cur;
      end
      return res;
   endfunction

   wire force_a = ctl_b_load && ctl_b_src[`AT8_B_FORCE_A] && !is_pwm;
   wire force_b = ctl_b_load && ctl_b_src[`AT8_B_FORCE_B] && !is_pwm;
   wire wrap = is_fast && at_top;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         compare_out_a_o <= 1'b0;
         compare_out_b_o <= 1'b0;
         compare_match_a_o <= 1'b0;
         compare_match_b_o <= 1'b0;
      end else begin
         // Forced events only touch the pins, never the match pulses
         compare_match_a_o <= tick && eq_a; // R02 R09
         compare_match_b_o <= tick && eq_b; // R02 R09
         if (force_a) begin
            compare_out_a_o <= out_next(act_a, compare_out_a_o, 1'b1,
                                        1'b0, count_up, 1'b1); // R01
         end else if (tick) begin
            compare_out_a_o <= out_next(act_a, compare_out_a_o, eq_a,
                                        wrap, count_up, 1'b1);
         end
         if (force_b) begin
            compare_out_b_o <= out_next(act_b, compare_out_b_o, 1'b1,
                                        1'b0, count_up, 1'b0); // R01
         end else if (tick) begin
            compare_out_b_o <= out_next(act_b, compare_out_b_o, eq_b,
                                        wrap, count_up, 1'b0);
         end
      end
   end

   // ==========================================================
   // Clock pin buffers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ext_clock_input_en_o <= 1'b0;
         xtal_osc_en_o <= 1'b0;
      end else begin
         ext_clock_input_en_o <= ext_clk_en && async_sel; // R10
         xtal_osc_en_o <= !ext_clk_en && async_sel; // R10
      end
   end

   // ==========================================================
   // Read mux and acknowledge
   wire [7:0] status_rd = {1'b0, ext_clk_en, async_sel,
                           slot_busy[AT8_SLOT_COUNT],
                           slot_busy[AT8_SLOT_CMP_A],
                           slot_busy[AT8_SLOT_CMP_B],
                           slot_busy[AT8_SLOT_CTL_A],
                           slot_busy[AT8_SLOT_CTL_B]}; // R14 R15
   logic [7:0] rd_byte;

   always_comb begin
      rd_byte = 8'h00;
      if (hit_count) begin
         rd_byte = count; // R17
      end else if (hit_cmp_a) begin
         rd_byte = slot_tmp[AT8_SLOT_CMP_A]; // R17
      end else if (hit_cmp_b) begin
         rd_byte = slot_tmp[AT8_SLOT_CMP_B]; // R17
      end else if (hit_ctl_a) begin
         rd_byte = slot_tmp[AT8_SLOT_CTL_A] & `AT8_A_RW_MASK;
      end else if (hit_ctl_b) begin
         rd_byte = slot_tmp[AT8_SLOT_CTL_B] & `AT8_B_RW_MASK; // R03 R05
      end else if (hit_status) begin
         rd_byte = status_rd;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= req;
         wb_dat_o <= req ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      end
   end
endmodule
`default_nettype wire

/* File: tb/at8_timer_monitor.sv */
// Concurrent checks on the timer's bus and clock-enable ports
`timescale 1ns/1ps
`default_nettype none
`include "at8_defs.svh"

module at8_timer_monitor (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic timer_osc_pin_i,
   input wire logic compare_out_a_o,
   input wire logic compare_out_b_o,
   input wire logic compare_match_a_o,
   input wire logic compare_match_b_o,
   input wire logic ext_clock_input_en_o,
   input wire logic xtal_osc_en_o
);
   wire rd_ack;
   wire mapped;
   assign rd_ack = wb_ack_o && !wb_we_i;
   assign mapped = wb_adr_i inside {`AT8_OFS_CTRL_A, `AT8_OFS_CTRL_B,
      `AT8_OFS_COUNT, `AT8_OFS_CMP_A, `AT8_OFS_CMP_B, `AT8_OFS_STATUS};

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   // ==========================================================
   // Bus handshake
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
      |=> wb_ack_o) else $error("request not acked on next cycle");
   a_ack_has_req: assert property ($rose(wb_ack_o)
      |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
   a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data not zero outside ack");
   a_dat_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
      else $error("read data upper bits not zero");

   // ==========================================================
   // Register read-back and clock pin enables
   a_ctlb_hi_zero: assert property (
      rd_ack && wb_adr_i == `AT8_OFS_CTRL_B |-> wb_dat_o[7:4] == 4'h0)
      else $error("control b strobe or reserved bits read nonzero");
   a_status_top_zero: assert property (
      rd_ack && wb_adr_i == `AT8_OFS_STATUS |-> !wb_dat_o[7])
      else $error("status bit 7 read nonzero");
   a_unmapped_zero: assert property (rd_ack && !mapped
      |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
   a_osc_excl: assert property (
      !(ext_clock_input_en_o && xtal_osc_en_o))
      else $error("crystal and external clock enabled together");
   a_clk_pins_follow: assert property (
      wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == `AT8_OFS_STATUS
      |=> {ext_clock_input_en_o, xtal_osc_en_o} ==
      $past({wb_dat_i[`AT8_S_EXT_CLK] && wb_dat_i[`AT8_S_ASYNC],
      !wb_dat_i[`AT8_S_EXT_CLK] && wb_dat_i[`AT8_S_ASYNC]}))
      else $error("clock pin enables do not follow status write");

   c_unmapped: cover property (rd_ack && !mapped);
   c_match_a: cover property (compare_match_a_o);
   c_ext_clk: cover property (ext_clock_input_en_o);
endmodule

bind at8_timer at8_timer_monitor mon_u (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .timer_osc_pin_i(timer_osc_pin_i),
   .compare_out_a_o(compare_out_a_o), .compare_out_b_o(compare_out_b_o),
   .compare_match_a_o(compare_match_a_o),
   .compare_match_b_o(compare_match_b_o),
   .ext_clock_input_en_o(ext_clock_input_en_o),
   .xtal_osc_en_o(xtal_osc_en_o));
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench for the 8-bit timer
`timescale 1ns/1ps
`default_nettype none
`include "at8_defs.svh"

module tb_top;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'hf;
   logic [31:0] wdat = 32'h0;
   logic [31:0] q;
   logic osc = 1'b0;
   logic osc_run = 1'b0;
   logic [7:0] c0;
   logic [7:0] d;
   wire [31:0] dat_o;
   wire ack;
   wire out_a;
   wire out_b;
   wire m_a;
   wire m_b;
   wire ext_en;
   wire xtal_en;
   int error_cnt = 0;
   int checks = 0;
   int cyc_n = 0;
   int ma_n = 0;
   int mb_n = 0;
   int osc_n = 0;
   int osc_div = 0;
   int divs[8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
   int lo;
   int n;
   int b0;

   at8_timer dut_u (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(dat_o), .wb_ack_o(ack), .timer_osc_pin_i(osc),
      .compare_out_a_o(out_a), .compare_out_b_o(out_b),
      .compare_match_a_o(m_a), .compare_match_b_o(m_b),
      .ext_clock_input_en_o(ext_en), .xtal_osc_en_o(xtal_en));

   initial begin
      forever #50 clk_i = ~clk_i;
   end

   // ==========================================================
   // Oscillator pin runs only when asked, 16 system clocks a period
   always @(posedge clk_i) begin
      cyc_n <= cyc_n + 1;
      if (m_a === 1'b1) ma_n <= ma_n + 1;
      if (m_b === 1'b1) mb_n <= mb_n + 1;
      if (osc_run) begin
         osc_div <= (osc_div == 7) ? 0 : osc_div + 1;
         if (osc_div == 7) osc <= ~osc;
         if (osc_div == 7 && !osc) osc_n <= osc_n + 1;
      end
      if (cyc_n == 30000) begin
         error_cnt++;
         finish_test();
      end
   end

   // ==========================================================
   // Bus and check tasks
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: seen %h expected %h", $time,
            seen, exp);
      end
   endtask

   // Called just after a rising edge; holds the request until ack is
   // sampled high at a rising edge, then leaves one idle cycle
   task automatic bus(input logic w, input logic [7:0] a,
         input logic [7:0] v);
      int k;
      k = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {24'h0, v};
      do begin
         @(posedge clk_i);
         k++;
      end while (ack !== 1'b1 && k < 20);
      q = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      if (k >= 20) chk(32'h0, 32'h1);
      @(posedge clk_i);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 8'h00);
      chk(q, exp);
   endtask

   task automatic finish_test;
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // ==========================================================
   // Test sequence
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(`AT8_OFS_STATUS, 32'h0);
      rd(`AT8_OFS_CTRL_B, 32'h0);
      rd(`AT8_OFS_CTRL_A, 32'h0);
      bus(1'b1, `AT8_OFS_CTRL_B, 8'hf8);
      rd(`AT8_OFS_CTRL_B, 32'h08);
      bus(1'b1, `AT8_OFS_CTRL_B, 8'h00);
      $display("test reset and control b done");

      bus(1'b1, `AT8_OFS_COUNT, 8'h5a);
      rd(`AT8_OFS_COUNT, 32'h5a);
      sel <= 4'h0;
      bus(1'b1, `AT8_OFS_COUNT, 8'h11);
      sel <= 4'hf;
      bus(1'b1, 8'h18, 8'hff);
      rd(8'h18, 32'h0);
      rd(`AT8_OFS_COUNT, 32'h5a);
      $display("test counter access done");

      for (int i = 0; i < 8; i++) begin
         bus(1'b1, `AT8_OFS_CTRL_B, 8'(i));
         bus(1'b0, `AT8_OFS_COUNT, 8'h00);
         c0 = q[7:0];
         repeat (i == 0 ? 40 : 4 * divs[i]) @(posedge clk_i);
         bus(1'b0, `AT8_OFS_COUNT, 8'h00);
         d = q[7:0] - c0;
         lo = (i == 0) ? 0 : (4 * divs[i] + 3) / divs[i];
         chk(d == lo[7:0] || (i > 0 && d == lo[7:0] + 8'h1), 1);
      end
      $display("test clock select done");

      // Stop the counter first so no stray match lands before b0
      bus(1'b1, `AT8_OFS_CTRL_B, 8'h00);
      bus(1'b1, `AT8_OFS_CTRL_A, 8'h40);
      bus(1'b1, `AT8_OFS_CMP_A, 8'h10);
      bus(1'b1, `AT8_OFS_COUNT, 8'h08);
      b0 = ma_n;
      bus(1'b1, `AT8_OFS_CTRL_B, 8'h01);
      repeat (30) @(posedge clk_i);
      chk(ma_n - b0, 1);
      chk(out_a, 1);
      bus(1'b1, `AT8_OFS_COUNT, 8'h10);
      b0 = ma_n;
      repeat (100) @(posedge clk_i);
      chk(ma_n - b0, 0);
      $display("test compare match done");

      bus(1'b1, `AT8_OFS_CTRL_B, 8'h00);
      bus(1'b1, `AT8_OFS_CTRL_A, 8'h72);
      bus(1'b1, `AT8_OFS_COUNT, 8'h10);
      b0 = ma_n + mb_n;
      bus(1'b1, `AT8_OFS_CTRL_B, 8'hc0);
      rd(`AT8_OFS_COUNT, 32'h10);
      chk(out_a, 0);
      chk(out_b, 1);
      chk(ma_n + mb_n - b0, 0);
      rd(`AT8_OFS_CTRL_B, 32'h0);
      $display("test force compare done");

      // Fast PWM: set at top, clear on match with compare A
      bus(1'b1, `AT8_OFS_CTRL_A, 8'h83);
      bus(1'b1, `AT8_OFS_CMP_A, 8'h80);
      bus(1'b1, `AT8_OFS_COUNT, 8'hf0);
      bus(1'b1, `AT8_OFS_CTRL_B, 8'h01);
      repeat (40) @(posedge clk_i);
      chk(out_a, 1);
      repeat (120) @(posedge clk_i);
      chk(out_a, 0);
      $display("test fast pwm done");

      bus(1'b1, `AT8_OFS_STATUS, 8'h40);
      repeat (3) @(posedge clk_i);
      chk({ext_en, xtal_en}, 2'b00);
      bus(1'b1, `AT8_OFS_STATUS, 8'h60);
      repeat (3) @(posedge clk_i);
      chk({ext_en, xtal_en}, 2'b10);
      bus(1'b1, `AT8_OFS_COUNT, 8'h20);
      bus(1'b1, `AT8_OFS_CMP_A, 8'h21);
      bus(1'b1, `AT8_OFS_CMP_B, 8'h22);
      bus(1'b1, `AT8_OFS_CTRL_A, 8'h00);
      bus(1'b1, `AT8_OFS_CTRL_B, 8'h01);
      rd(`AT8_OFS_STATUS, 32'h7f);
      rd(`AT8_OFS_CMP_B, 32'h22);
      rd(`AT8_OFS_CTRL_B, 32'h01);
      repeat (30) @(posedge clk_i);
      rd(`AT8_OFS_STATUS, 32'h7f);
      b0 = osc_n;
      osc_run <= 1'b1;
      n = 0;
      do begin
         bus(1'b0, `AT8_OFS_STATUS, 8'h00);
         n++;
      end while (q[4:0] !== 5'h0 && n < 40);
      chk(q, 32'h60);
      chk(osc_n - b0 >= 2, 1);
      bus(1'b0, `AT8_OFS_COUNT, 8'h00);
      c0 = q[7:0];
      repeat (64) @(posedge clk_i);
      bus(1'b0, `AT8_OFS_COUNT, 8'h00);
      d = q[7:0] - c0;
      chk(d >= 8'h3 && d <= 8'h5, 1);
      bus(1'b1, `AT8_OFS_STATUS, 8'h20);
      repeat (3) @(posedge clk_i);
      chk({ext_en, xtal_en}, 2'b01);
      osc_run <= 1'b0;
      $display("test async path done");
      finish_test();
   end
endmodule
`default_nettype wire
